// ---- hdl/bbgc_cfg.svh ----
// constants for the boot and bus grant control block
`ifndef BBGC_CFG_SVH
`define BBGC_CFG_SVH
`define BBGC_STRAP_W        3
`define BBGC_STRAP_BYTE_WIDE 3'h0
`define BBGC_STRAP_NO_BOOT  3'h2
`define BBGC_STRAP_BYTE_HOST 3'h4
`define BBGC_STRAP_HOST_DMA 3'h5
`define BBGC_COUNT_W        14
`define BBGC_BOOT_WORDS     14'h020
`define BBGC_FMT_PM24       2'h0
`define BBGC_PAGE_RST       8'h00
`define BBGC_ADDR_RST       14'h0000
`define BBGC_DIR_RST        1'h0
`endif

// ---- hdl/bbgc_pkg.sv ----
// types shared by the boot and bus grant control block
package bbgc_pkg;
    // decoded start-up behaviour
    typedef enum logic [2:0] {
        BBGC_BOOT_BYTE_WIDE = 3'h0,
        BBGC_BOOT_NONE      = 3'h1,
        BBGC_BOOT_BYTE_HOST = 3'h2,
        BBGC_BOOT_HOST_DMA  = 3'h3,
        BBGC_BOOT_UNDEF     = 3'h4
    } bbgc_boot_t;
    // external bus ownership
    typedef enum logic [1:0] {
        BBGC_BUS_OWN   = 2'h0,
        BBGC_BUS_WAIT  = 2'h1,
        BBGC_BUS_GRANT = 2'h2
    } bbgc_bus_t;
    // byte memory transfer set-up
    typedef struct packed {
        logic        transfer_direction;
        logic [7:0]  byte_page_number;
        logic [13:0] internal_start_addr;
        logic [13:0] external_start_addr;
        logic [1:0]  word_format;
        logic [13:0] word_transfer_count;
    } bbgc_dma_cfg_t;
endpackage

// ---- hdl/bbgc_top.sv ----
// boot control and external bus request/grant handshake
`include "bbgc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module bbgc_top
(
    // clock and resets
    input  wire logic                  i_mclk,
    input  wire logic                  i_arst_n,
    input  wire logic                  i_por_arst_n,
    // strap pins
    input  wire logic [2:0]            i_boot_strap,
    // external bus master
    input  wire logic                  i_bus_request,
    output logic                       o_bus_grant,
    output logic                       o_grant_hold_flag,
    output logic                       o_mem_oe_n,
    // core status
    input  wire logic                  i_ext_access_busy,
    input  wire logic                  i_ext_access_done,
    input  wire logic                  i_need_ext_access,
    input  wire logic                  i_run_on_grant_mode,
    // byte memory transfer engine
    input  wire logic                  i_count_wr,
    input  wire logic [13:0]           i_count_wdata,
    input  wire logic                  i_hold_wr,
    input  wire logic                  i_hold_wdata,
    input  wire logic                  i_word_done,
    output bbgc_pkg::bbgc_dma_cfg_t    o_dma_cfg,
    output logic                       o_dma_active,
    output logic                       o_boot_hold_bit,
    // host port
    input  wire logic                  i_host_pm0_write,
    // core control
    output logic                       o_exec_stall,
    output logic                       o_ctx_restart,
    output logic                       o_fetch_external,
    output logic                       o_host_mode,
    output logic                       o_lowest_addr_only
);
    // ********************************************************
    // reset synchronisers
    // ********************************************************
    logic [1:0] rst_sync_r;   // device reset release chain
    logic [1:0] por_sync_r;   // power-on reset release chain
    wire        rst_n = rst_sync_r[1];   // synchronised device reset
    wire        por_n = por_sync_r[1];   // synchronised power-on reset
    // device reset released through two flops
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    // grant side has its own reset so device reset cannot block it
    always_ff @(posedge i_mclk or negedge i_por_arst_n)
    begin
        if (!i_por_arst_n)
            por_sync_r <= 2'h0;
        else
            por_sync_r <= {por_sync_r[0], 1'b1};
    end
    // ********************************************************
    // strap capture
    // ********************************************************
    logic                 strap_done_r;  // strap caught after release
    bbgc_pkg::bbgc_boot_t boot_r;        // decoded mode
    bbgc_pkg::bbgc_boot_t boot_nxt;      // decode of the pins
    wire                  capture = !strap_done_r;  // first cycle after release
    logic                 byte_boot;     // either byte boot strap
    always_comb
    begin
        case (i_boot_strap)
            `BBGC_STRAP_BYTE_WIDE: boot_nxt = bbgc_pkg::BBGC_BOOT_BYTE_WIDE;
            `BBGC_STRAP_NO_BOOT:   boot_nxt = bbgc_pkg::BBGC_BOOT_NONE;
            `BBGC_STRAP_BYTE_HOST: boot_nxt = bbgc_pkg::BBGC_BOOT_BYTE_HOST;
            `BBGC_STRAP_HOST_DMA:  boot_nxt = bbgc_pkg::BBGC_BOOT_HOST_DMA;
            default:               boot_nxt = bbgc_pkg::BBGC_BOOT_UNDEF;
        endcase
    end
    assign byte_boot = (boot_nxt == bbgc_pkg::BBGC_BOOT_BYTE_WIDE) || (boot_nxt == bbgc_pkg::BBGC_BOOT_BYTE_HOST);
    // strap is caught by a clocked process after release
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_done_r <= 1'b0;
            boot_r       <= bbgc_pkg::BBGC_BOOT_UNDEF;
        end
        else if (capture)
        begin
            strap_done_r <= 1'b1;
            boot_r       <= boot_nxt;
        end
    end
    // mode outputs
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_fetch_external   <= 1'b0;
            o_host_mode        <= 1'b0;
            o_lowest_addr_only <= 1'b0;
        end
        else
        begin
            // no boot starts at external zero
            o_fetch_external   <= (boot_r == bbgc_pkg::BBGC_BOOT_NONE);
            o_host_mode        <= (boot_r == bbgc_pkg::BBGC_BOOT_BYTE_HOST) ||
                                  (boot_r == bbgc_pkg::BBGC_BOOT_HOST_DMA);
            // host byte boot drives only the lowest line
            o_lowest_addr_only <= (boot_r == bbgc_pkg::BBGC_BOOT_BYTE_HOST);
        end
    end
    // ********************************************************
    // byte memory transfer setup and count
    // ********************************************************
    wire count_zero = (o_dma_cfg.word_transfer_count == 14'h0000);   // transfer finished
    wire last_word  = i_word_done && (o_dma_cfg.word_transfer_count == 14'h0001);   // final word this cycle
    // reset defaults for the transfer setup
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_dma_cfg.transfer_direction  <= `BBGC_DIR_RST;
            o_dma_cfg.byte_page_number    <= `BBGC_PAGE_RST;
            o_dma_cfg.internal_start_addr <= `BBGC_ADDR_RST;
            o_dma_cfg.external_start_addr <= `BBGC_ADDR_RST;
            o_dma_cfg.word_format         <= `BBGC_FMT_PM24;
            o_dma_cfg.word_transfer_count <= `BBGC_BOOT_WORDS;
        end
        // byte boot keeps count 32 at release, others drop it
        else if (capture && !byte_boot)
            o_dma_cfg.word_transfer_count <= 14'h0000;
        else if (i_count_wr)
            o_dma_cfg.word_transfer_count <= i_count_wdata;
        else if (i_word_done && !count_zero)
            o_dma_cfg.word_transfer_count <= o_dma_cfg.word_transfer_count - 14'h0001;
    end
    // transfer busy flag
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
            o_dma_active <= 1'b0;
        else
            o_dma_active <= strap_done_r && !count_zero && !last_word;
    end
    // ********************************************************
    // boot hold and restart
    // ********************************************************
    logic host_wait_r;   // waiting for program word zero
    // hold bit set for byte boot
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
            o_boot_hold_bit <= 1'b0;
        else if (capture)
            o_boot_hold_bit <= byte_boot;
        else if (i_hold_wr)
            o_boot_hold_bit <= i_hold_wdata;
    end
    // host port boot waits for program word zero
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
            host_wait_r <= 1'b0;
        else if (capture)
            host_wait_r <= (boot_nxt == bbgc_pkg::BBGC_BOOT_HOST_DMA);
        else if (i_host_pm0_write)
            host_wait_r <= 1'b0;
    end
    // context restart at zero when held transfer ends
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
            o_ctx_restart <= 1'b0;
        else
            o_ctx_restart <= o_boot_hold_bit && last_word;
    end
    // ********************************************************
    // bus request and grant
    // ********************************************************
    logic                req_meta_r;  // first synchroniser stage
    logic                req_r;       // second synchroniser stage
    bbgc_pkg::bbgc_bus_t bus_r;       // bus owner state
    bbgc_pkg::bbgc_bus_t bus_nxt;     // next owner state
    always_ff @(posedge i_mclk or negedge por_n)
    begin
        if (!por_n)
        begin
            req_meta_r <= 1'b0;
            req_r      <= 1'b0;
        end
        else
        begin
            req_meta_r <= i_bus_request;
            req_r      <= req_meta_r;
        end
    end
    // grant decision
    always_comb
    begin
        bus_nxt = bus_r;
        case (bus_r)
            bbgc_pkg::BBGC_BUS_OWN:
            begin
                // busy bus waits for access to end
                if (req_r && i_ext_access_busy && !i_ext_access_done)
                    bus_nxt = bbgc_pkg::BBGC_BUS_WAIT;
                else if (req_r)
                    bus_nxt = bbgc_pkg::BBGC_BUS_GRANT;
            end
            bbgc_pkg::BBGC_BUS_WAIT:
            begin
                // grant at access end, not instruction end
                if (!req_r)
                    bus_nxt = bbgc_pkg::BBGC_BUS_OWN;
                else if (i_ext_access_done)
                    bus_nxt = bbgc_pkg::BBGC_BUS_GRANT;
            end
            bbgc_pkg::BBGC_BUS_GRANT:
            begin
                if (!req_r)
                    bus_nxt = bbgc_pkg::BBGC_BUS_OWN;
            end
            default:
                bus_nxt = bbgc_pkg::BBGC_BUS_OWN;
        endcase
    end
    wire granted = (bus_nxt == bbgc_pkg::BBGC_BUS_GRANT);   // grant in the next state
    // grant logic runs under power-on reset only
    always_ff @(posedge i_mclk or negedge por_n)
    begin
        if (!por_n)
        begin
            bus_r       <= bbgc_pkg::BBGC_BUS_OWN;
            o_bus_grant <= 1'b0;
            o_mem_oe_n  <= 1'b1;
        end
        else
        begin
            bus_r       <= bus_nxt;
            o_bus_grant <= granted;
            o_mem_oe_n  <= granted || !rst_n;
        end
    end
    // ********************************************************
    // execution stall and grant hold
    // ********************************************************
    // stall from boot
    wire boot_stall = !strap_done_r || host_wait_r || (o_boot_hold_bit && !count_zero && !last_word);
    // run_on_grant only stops on external access
    wire wants_bus  = !i_run_on_grant_mode || i_need_ext_access;
    // stall and hold flag
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_exec_stall      <= 1'b1;
            o_grant_hold_flag <= 1'b0;
        end
        else
        begin
            o_exec_stall      <= boot_stall || (granted && wants_bus);
            // blocked by grant, cleared on release
            o_grant_hold_flag <= !boot_stall && granted && wants_bus;
        end
    end
endmodule
`default_nettype wire

// ---- verif/bbgc_bus_master.sv ----
// external bus master model
`timescale 1ns/1ps
`default_nettype none
module bbgc_bus_master
(
    // clock and command
    input wire logic i_mclk,
    input wire logic i_want,
    // device side
    input wire logic i_bus_grant,
    output logic     o_bus_request,
    output logic     o_owns_bus
);
    always @(posedge i_mclk) o_bus_request <= i_want;
    // bus is ours only once granted
    assign o_owns_bus = o_bus_request && i_bus_grant;
endmodule
`default_nettype wire

// ---- verif/bbgc_checker.sv ----
// assertions on the boot and bus grant ports
`timescale 1ns/1ps
`default_nettype none
module bbgc_checker
(
    // clock and resets
    input wire logic                    i_mclk,
    input wire logic                    i_arst_n,
    input wire logic                    i_por_arst_n,
    // inputs watched
    input wire logic                    i_bus_request,
    input wire logic                    i_ext_access_busy,
    input wire logic                    i_ext_access_done,
    input wire logic                    i_count_wr,
    input wire logic [13:0]             i_count_wdata,
    input wire logic                    i_word_done,
    // outputs watched
    input wire logic                    o_bus_grant,
    input wire logic                    o_grant_hold_flag,
    input wire logic                    o_mem_oe_n,
    input wire bbgc_pkg::bbgc_dma_cfg_t o_dma_cfg,
    input wire logic                    o_dma_active,
    input wire logic                    o_exec_stall,
    input wire logic                    o_ctx_restart
);
    // one clock for every property
    default clocking cb @(posedge i_mclk);
    endclocking
    a_idle_bus_grant: assert property (disable iff (!i_por_arst_n)
        $rose(i_bus_request) ##2 (i_bus_request && !i_ext_access_busy) |=> o_bus_grant)
        else $error("grant late on idle bus");
    a_busy_defer: assert property (disable iff (!i_por_arst_n)
        $rose(o_bus_grant) |-> !$past(i_ext_access_busy) || $past(i_ext_access_done))
        else $error("grant during external access");
    a_grant_release: assert property (disable iff (!i_por_arst_n)
        $fell(i_bus_request) ##2 1'h1 |=> !o_bus_grant)
        else $error("grant kept after release");
    a_grant_float: assert property (disable iff (!i_por_arst_n)
        o_bus_grant |-> o_mem_oe_n)
        else $error("bus driven while granted");
    a_hold_granted: assert property (disable iff (!i_por_arst_n)
        o_grant_hold_flag |-> o_bus_grant)
        else $error("hold flag without grant");
    a_count_dec: assert property (disable iff (!i_arst_n)
        o_dma_active && i_word_done && !i_count_wr |=>
        o_dma_cfg.word_transfer_count == $past(o_dma_cfg.word_transfer_count) - 14'h0001)
        else $error("count not decremented");
    a_count_load: assert property (disable iff (!i_arst_n)
        i_count_wr && $past(i_arst_n, 4) |=> o_dma_cfg.word_transfer_count == $past(i_count_wdata))
        else $error("count write lost");
    // restart only at end of load
    a_restart_done: assert property (disable iff (!i_arst_n)
        o_ctx_restart |-> (o_dma_cfg.word_transfer_count == 14'h0000 && !o_dma_active && !o_exec_stall)
        ##1 !o_ctx_restart)
        else $error("restart pulse wrong");
endmodule
bind bbgc_top bbgc_checker chk_i (.i_mclk, .i_arst_n, .i_por_arst_n, .i_bus_request,
    .i_ext_access_busy, .i_ext_access_done, .i_count_wr, .i_count_wdata, .i_word_done,
    .o_bus_grant, .o_grant_hold_flag, .o_mem_oe_n, .o_dma_cfg, .o_dma_active,
    .o_exec_stall, .o_ctx_restart);
`default_nettype wire

// ---- verif/bbgc_top_tb.sv ----
// bench for boot and bus grant control
`timescale 1ns/1ps
`default_nettype none
module bbgc_top_tb;
    // clock, resets, stimulus
    logic i_mclk = 1'h0, i_arst_n = 1'h0, i_por_arst_n = 1'h0, want = 1'h0;
    logic i_ext_access_busy = 1'h0, i_ext_access_done = 1'h0, i_need_ext_access = 1'h0;
    logic i_run_on_grant_mode = 1'h0, i_count_wr = 1'h0, i_hold_wr = 1'h0, i_hold_wdata = 1'h0;
    logic i_word_done = 1'h0, i_host_pm0_write = 1'h0;
    logic [2:0] i_boot_strap = 3'h0;
    logic [13:0] i_count_wdata = 14'h0000;
    // observed
    logic i_bus_request, o_bus_grant, o_grant_hold_flag, o_mem_oe_n, o_dma_active, owns;
    logic o_boot_hold_bit, o_exec_stall, o_ctx_restart, o_fetch_external, o_host_mode, o_lowest_addr_only;
    bbgc_pkg::bbgc_dma_cfg_t o_dma_cfg;
    int num_errors = 0;
    int check_count = 0;
    // 4 ns clock
    always #2 i_mclk = ~i_mclk;
    bbgc_top uut (.i_mclk, .i_arst_n, .i_por_arst_n, .i_boot_strap, .i_bus_request, .o_bus_grant,
        .o_grant_hold_flag, .o_mem_oe_n, .i_ext_access_busy, .i_ext_access_done, .i_need_ext_access,
        .i_run_on_grant_mode, .i_count_wr, .i_count_wdata, .i_hold_wr, .i_hold_wdata, .i_word_done,
        .o_dma_cfg, .o_dma_active, .o_boot_hold_bit, .i_host_pm0_write, .o_exec_stall, .o_ctx_restart,
        .o_fetch_external, .o_host_mode, .o_lowest_addr_only);
    bbgc_bus_master master (.i_mclk, .i_want(want), .i_bus_grant(o_bus_grant),
        .o_bus_request(i_bus_request), .o_owns_bus(owns));
    // compare one value
    task automatic chk(input string what, input logic [51:0] exp, input logic [51:0] got);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // wait edges, then settle
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    // device reset with strap
    task automatic do_reset(input logic [2:0] s);
        @(posedge i_mclk) i_arst_n <= 1'h0;
        i_boot_strap <= s;
        tick(3);
        chk("cfg_rst", 52'h0000000000020, o_dma_cfg);
        chk("stall_rst", 1'h1, o_exec_stall);
        @(posedge i_mclk) i_arst_n <= 1'h1;
        tick(6);
    endtask
    // request or release, check grant edge
    task automatic bus_req(input logic v);
        @(posedge i_mclk) want <= v;
        tick(3);
        chk("grant_early", !v, o_bus_grant);
        tick(1);
        chk("grant", v, o_bus_grant);
    endtask
    // byte boot of 32 words
    task automatic t_byte_boot(input logic [2:0] s, input logic h);
        do_reset(s);
        chk("hold_bit", 1'h1, o_boot_hold_bit);
        chk("active", 1'h1, o_dma_active);
        chk("host", h, o_host_mode);
        chk("low_addr", h, o_lowest_addr_only);
        @(posedge i_mclk) i_word_done <= 1'h1;
        tick(31);
        chk("count_one", 14'h0001, o_dma_cfg.word_transfer_count);
        chk("stall_load", 1'h1, o_exec_stall);
        @(posedge i_mclk) i_word_done <= 1'h0;
        #1;
        chk("restart", 1'h1, o_ctx_restart);
        chk("stall_end", 1'h0, o_exec_stall);
        tick(1);
        chk("restart_off", 1'h0, o_ctx_restart);
        $display("test byte boot %h ended", s);
    endtask
    // host port boot
    task automatic t_host_dma;
        do_reset(3'h5);
        chk("host", 1'h1, o_host_mode);
        chk("low_addr", 1'h0, o_lowest_addr_only);
        tick(5);
        chk("stall_wait", 1'h1, o_exec_stall);
        @(posedge i_mclk) i_host_pm0_write <= 1'h1;
        @(posedge i_mclk) i_host_pm0_write <= 1'h0;
        tick(1);
        chk("stall_pm0", 1'h0, o_exec_stall);
        $display("test host boot ended");
    endtask
    // no boot, manual transfer
    task automatic t_no_boot;
        do_reset(3'h2);
        chk("fetch", 1'h1, o_fetch_external);
        chk("no_stall", 1'h0, o_exec_stall);
        @(posedge i_mclk) i_count_wr <= 1'h1;
        i_count_wdata <= 14'h0003;
        @(posedge i_mclk) i_count_wr <= 1'h0;
        tick(1);
        chk("active", 1'h1, o_dma_active);
        chk("no_wait", 1'h0, o_exec_stall);
        @(posedge i_mclk) i_word_done <= 1'h1;
        tick(2);
        chk("count_one", 14'h0001, o_dma_cfg.word_transfer_count);
        @(posedge i_mclk) i_word_done <= 1'h0;
        #1;
        chk("idle", 1'h0, o_dma_active);
        chk("no_restart", 1'h0, o_ctx_restart);
        @(posedge i_mclk) i_hold_wr <= 1'h1;
        i_hold_wdata <= 1'h1;
        i_count_wr <= 1'h1;
        i_count_wdata <= 14'h0001;
        @(posedge i_mclk) i_hold_wr <= 1'h0;
        i_count_wr <= 1'h0;
        tick(1);
        chk("hold_set", 1'h1, o_boot_hold_bit);
        chk("held", 1'h1, o_exec_stall);
        @(posedge i_mclk) i_word_done <= 1'h1;
        @(posedge i_mclk) i_word_done <= 1'h0;
        #1;
        chk("restart_hw", 1'h1, o_ctx_restart);
        chk("resume_hw", 1'h0, o_exec_stall);
        $display("test no boot ended");
    endtask
    // grant and release, halt mode
    task automatic t_grant;
        bus_req(1'h1);
        chk("float", 1'h1, o_mem_oe_n);
        chk("halt", 1'h1, o_exec_stall);
        chk("hold_flag", 1'h1, o_grant_hold_flag);
        chk("owns", 1'h1, owns);
        bus_req(1'h0);
        chk("drive", 1'h0, o_mem_oe_n);
        chk("resume", 1'h0, o_exec_stall);
        chk("hold_clear", 1'h0, o_grant_hold_flag);
        $display("test grant ended");
    endtask
    // keep running under grant
    task automatic t_run;
        @(posedge i_mclk) i_run_on_grant_mode <= 1'h1;
        bus_req(1'h1);
        chk("go_on", 1'h0, o_exec_stall);
        @(posedge i_mclk) i_need_ext_access <= 1'h1;
        tick(1);
        chk("ext_stall", 1'h1, o_exec_stall);
        chk("hold_flag", 1'h1, o_grant_hold_flag);
        bus_req(1'h0);
        chk("hold_clear", 1'h0, o_grant_hold_flag);
        @(posedge i_mclk) i_need_ext_access <= 1'h0;
        i_run_on_grant_mode <= 1'h0;
        $display("test run on grant ended");
    endtask
    // request during an access
    task automatic t_busy;
        @(posedge i_mclk) i_ext_access_busy <= 1'h1;
        want <= 1'h1;
        tick(8);
        chk("deferred", 1'h0, o_bus_grant);
        @(posedge i_mclk) i_ext_access_done <= 1'h1;
        @(posedge i_mclk) i_ext_access_done <= 1'h0;
        i_ext_access_busy <= 1'h0;
        #1;
        chk("after_done", 1'h1, o_bus_grant);
        bus_req(1'h0);
        $display("test busy grant ended");
    endtask
    // request while device reset held
    task automatic t_reset_req;
        @(posedge i_mclk) i_arst_n <= 1'h0;
        bus_req(1'h1);
        bus_req(1'h0);
        chk("float_rst", 1'h1, o_mem_oe_n);
        do_reset(3'h7);
        chk("fetch_undef", 1'h0, o_fetch_external);
        chk("run_undef", 1'h0, o_exec_stall);
        $display("test grant in reset ended");
    endtask
    // verdict and end of run
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (4) @(posedge i_mclk);
        i_por_arst_n <= 1'h1;
        t_byte_boot(3'h0, 1'h0);
        t_byte_boot(3'h4, 1'h1);
        t_host_dma();
        t_no_boot();
        t_grant();
        t_run();
        t_busy();
        t_reset_req();
        finish_test();
    end
    // watchdog
    initial
    begin
        repeat (5000) @(posedge i_mclk);
        num_errors++;
        finish_test();
    end
endmodule
`default_nettype wire
